//--- hw/vms_top.sv
// measurement run control, overall holds, range flags, led and raw record packing
//
// Functional notes
// - a new run clears all overall results of the previous run first
// - changed filters or sensor delay start by settling time, green blinking
// - power button held one second while red starts run, unless sensor id busy
// - overall results for three axes and sum republished once per second
// - run-long hold of square sum, minimum and maximum per channel
// - overload flagged when any axis exceeds input range
// - current overload drives led solid yellow
// - overload seen during run blinks led green and yellow
// - overload flag stays until next run start or power cycle
// - under-range flagged when signal is too low to measure
// - raw record is 12 bytes: x at 0..3, y at 4..7, z at 8..11
// - each axis float sits least significant byte first
// - raw values pass scaled but unweighted, unintegrated, with dc offset
// - run annotations accepted without stopping the run
// - one pre-run overall note, still editable after the run
//
// The Avalon-MM slave port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`include "vms_regs.svh"

module vms_top
  import vms_pkg::*;
#(
  parameter int          MAG_W      = 16,
  parameter logic [31:0] SETTLE_CYC = 32'(`VMS_SETTLE_S * `VMS_CLK_HZ),
  parameter logic [31:0] HOLD_CYC   = 32'(`VMS_HOLD_MS * `VMS_CLK_HZ / `VMS_MS_PER_S),
  parameter logic [31:0] TICK_CYC   = 32'(`VMS_CLK_HZ),
  parameter logic [31:0] BLINK_CYC  = 32'(`VMS_BLINK_MS * `VMS_CLK_HZ / `VMS_MS_PER_S)
) (
  input  wire logic            CLK_IN,
  input  wire logic            RST_B_IN,
  input  wire logic [7:0]      ADDRESS_IN,
  input  wire logic            READ_IN,
  input  wire logic            WRITE_IN,
  input  wire logic [31:0]     WRITEDATA_IN,
  input  wire logic [3:0]      BYTEENABLE_IN,
  output logic      [31:0]     READDATA_OUT,
  output logic                 WAITREQUEST_OUT,
  input  wire vms_axis_t [2:0] SAMPLE_IN,
  input  wire logic            SAMPLE_VALID_IN,
  input  wire logic [2:0]      OVER_IN,
  input  wire logic [2:0]      UNDER_IN,
  input  wire logic            SENSOR_CHANGE_IN,
  input  wire logic            TEDS_BUSY_IN,
  input  wire logic            BUTTON_IN,
  output logic                 LED_RED_OUT,
  output logic                 LED_GREEN_OUT,
  output logic                 OVERLOAD_OUT,
  output logic                 UNDER_RANGE_OUT,
  output vms_rec_t             RAW_REC_OUT,
  output logic                 RAW_VALID_OUT
);

  localparam int CH_W  = MAG_W + 2;
  localparam int ACC_W = 2 * CH_W + 12;

  // ****************************************************
  // bus slave
  // ****************************************************
  logic        wait_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rd_mux;
  wire         bus_req  = READ_IN | WRITE_IN;
  wire         wr_ack   = WRITE_IN & ~wait_reg;
  wire  [31:0] be_mask  = {{8{BYTEENABLE_IN[3]}}, {8{BYTEENABLE_IN[2]}},
                           {8{BYTEENABLE_IN[1]}}, {8{BYTEENABLE_IN[0]}}};
  wire  [31:0] wdata    = WRITEDATA_IN & be_mask;
  wire         wr_ctrl  = wr_ack & (ADDRESS_IN == `VMS_CTRL_OFS);
  wire         wr_npre  = wr_ack & (ADDRESS_IN == `VMS_NOTE_PRE_OFS);
  wire         wr_nrun  = wr_ack & (ADDRESS_IN == `VMS_NOTE_RUN_OFS);
  wire         ch_hit   = (ADDRESS_IN[7:4] >= `VMS_CH_BASE) &&
                          (ADDRESS_IN[7:4] <= `VMS_CH_LAST);
  wire  [1:0]  ch_idx   = 2'(ADDRESS_IN[7:4] - `VMS_CH_BASE);
  wire  [1:0]  ch_fld   = ADDRESS_IN[3:2];

  // one wait cycle, then a single ready cycle
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      wait_reg  <= 1'b1;
      rdata_reg <= 32'h0;
    end else begin
      wait_reg <= ~(bus_req & wait_reg);
      if (READ_IN && wait_reg) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  assign READDATA_OUT    = rdata_reg;
  assign WAITREQUEST_OUT = wait_reg;

  // ****************************************************
  // run control
  // ****************************************************
  vms_state_t  state_reg;
  vms_state_t  state_next;
  logic        raw_en_reg;
  logic        dirty_reg;
  logic [31:0] settle_cnt_reg;
  logic [31:0] hold_cnt_reg;
  logic [31:0] tick_cnt_reg;
  logic [31:0] blink_cnt_reg;
  logic        blink_reg;

  wire sw_start    = wr_ctrl & wdata[`VMS_CTRL_START];
  wire stop_req    = wr_ctrl & wdata[`VMS_CTRL_STOP];
  wire btn_armed   = (state_reg == VMS_IDLE) & ~TEDS_BUSY_IN;
  wire btn_fire    = btn_armed & BUTTON_IN & (hold_cnt_reg == HOLD_CYC - 32'h1);
  wire start_req   = sw_start | btn_fire;
  wire settle_done = (state_reg == VMS_SETTLE) & (settle_cnt_reg == 32'h0);
  wire tick        = tick_cnt_reg == TICK_CYC - 32'h1;
  wire running     = state_reg == VMS_RUN;
  wire dirty_set   = SENSOR_CHANGE_IN | (wr_ctrl & wdata[`VMS_CTRL_CFGCHG]);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      VMS_IDLE: begin
        if (start_req && !stop_req) begin
          state_next = dirty_reg ? VMS_SETTLE : VMS_RUN;
        end
      end
      VMS_SETTLE: begin
        if (stop_req) begin
          state_next = VMS_IDLE;
        end else if (settle_done) begin
          state_next = VMS_RUN;
        end
      end
      VMS_RUN: begin
        if (stop_req) begin
          state_next = VMS_IDLE;
        end else if (start_req) begin
          state_next = dirty_reg ? VMS_SETTLE : VMS_RUN;
        end
      end
    endcase
  end

  // a restart while running also counts as a fresh start
  wire clr = (state_next == VMS_RUN) &&
             ((state_reg != VMS_RUN) || (start_req && !stop_req));

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      state_reg  <= VMS_IDLE;
      raw_en_reg <= `VMS_RAW_EN_RST;
      dirty_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (wr_ctrl && BYTEENABLE_IN[0]) begin
        raw_en_reg <= wdata[`VMS_CTRL_RAW];
      end
      if (dirty_set) begin
        dirty_reg <= 1'b1;
      end else if (settle_done) begin
        dirty_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      settle_cnt_reg <= 32'h0;
      hold_cnt_reg   <= 32'h0;
    end else begin
      if (state_reg != VMS_SETTLE) begin
        settle_cnt_reg <= SETTLE_CYC - 32'h1;
      end else if (settle_cnt_reg != 32'h0) begin
        settle_cnt_reg <= settle_cnt_reg - 32'h1;
      end
      if (btn_armed && BUTTON_IN && !btn_fire) begin
        hold_cnt_reg <= hold_cnt_reg + 32'h1;
      end else begin
        hold_cnt_reg <= 32'h0;
      end
    end
  end

  // second tick restarted at each run start, free running blink divider
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      tick_cnt_reg  <= 32'h0;
      blink_cnt_reg <= 32'h0;
      blink_reg     <= 1'b0;
    end else begin
      tick_cnt_reg <= (tick || clr) ? 32'h0 : tick_cnt_reg + 32'h1;
      if (blink_cnt_reg == BLINK_CYC - 32'h1) begin
        blink_cnt_reg <= 32'h0;
        blink_reg     <= ~blink_reg;
      end else begin
        blink_cnt_reg <= blink_cnt_reg + 32'h1;
      end
    end
  end

  // ****************************************************
  // overall holds: three axes plus summation
  // ****************************************************
  logic [CH_W-1:0]  ch_mag         [4];
  logic [ACC_W-1:0] acc_sumsq_reg  [4];
  logic [CH_W-1:0]  acc_min_reg    [4];
  logic [CH_W-1:0]  acc_max_reg    [4];
  logic [31:0]      pub_sumsq_reg  [4];
  logic [CH_W-1:0]  pub_min_reg    [4];
  logic [CH_W-1:0]  pub_max_reg    [4];
  logic [31:0]      samp_cnt_reg;
  logic [31:0]      pub_cnt_reg;
  wire              take = running & SAMPLE_VALID_IN;

  assign ch_mag[3] = CH_W'(SAMPLE_IN[0].mag) + CH_W'(SAMPLE_IN[1].mag)
                   + CH_W'(SAMPLE_IN[2].mag);

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_ch
      if (gi < 3) begin : g_axis
        assign ch_mag[gi] = CH_W'(SAMPLE_IN[gi].mag);
      end
      always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
          acc_sumsq_reg[gi] <= '0;
          acc_min_reg[gi]   <= '1;
          acc_max_reg[gi]   <= '0;
          pub_sumsq_reg[gi] <= 32'h0;
          pub_min_reg[gi]   <= '0;
          pub_max_reg[gi]   <= '0;
        end else if (clr) begin
          acc_sumsq_reg[gi] <= '0;
          acc_min_reg[gi]   <= '1;
          acc_max_reg[gi]   <= '0;
          pub_sumsq_reg[gi] <= 32'h0;
          pub_min_reg[gi]   <= '0;
          pub_max_reg[gi]   <= '0;
        end else begin
          if (take) begin
            acc_sumsq_reg[gi] <= acc_sumsq_reg[gi]
                               + ACC_W'(ch_mag[gi] * ch_mag[gi]);
            if (ch_mag[gi] < acc_min_reg[gi]) begin
              acc_min_reg[gi] <= ch_mag[gi];
            end
            if (ch_mag[gi] > acc_max_reg[gi]) begin
              acc_max_reg[gi] <= ch_mag[gi];
            end
          end
          if (tick && running) begin
            pub_sumsq_reg[gi] <= acc_sumsq_reg[gi][ACC_W-1:ACC_W-32];
            pub_min_reg[gi]   <= acc_min_reg[gi];
            pub_max_reg[gi]   <= acc_max_reg[gi];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      samp_cnt_reg <= 32'h0;
      pub_cnt_reg  <= 32'h0;
    end else if (clr) begin
      samp_cnt_reg <= 32'h0;
      pub_cnt_reg  <= 32'h0;
    end else begin
      if (take) begin
        samp_cnt_reg <= samp_cnt_reg + 32'h1;
      end
      if (tick && running) begin
        pub_cnt_reg <= samp_cnt_reg;
      end
    end
  end

  // ****************************************************
  // range flags and status led
  // ****************************************************
  logic ovl_now_reg;
  logic overload_flag_reg;
  logic under_reg;
  logic led_r_reg;
  logic led_g_reg;
  logic led_r_next;
  logic led_g_next;

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      ovl_now_reg       <= 1'b0;
      overload_flag_reg <= 1'b0;
      under_reg         <= 1'b0;
      led_r_reg         <= 1'b0;
      led_g_reg         <= 1'b0;
    end else begin
      ovl_now_reg <= |OVER_IN;
      under_reg   <= |UNDER_IN;
      // an overload while running wins over the restart that clears the flag
      if (running && |OVER_IN) begin
        overload_flag_reg <= 1'b1;
      end else if (clr) begin
        overload_flag_reg <= 1'b0;
      end
      led_r_reg <= led_r_next;
      led_g_reg <= led_g_next;
    end
  end

  always_comb begin
    led_r_next = 1'b1;
    led_g_next = 1'b0;
    if (ovl_now_reg) begin
      led_r_next = 1'b1;
      led_g_next = 1'b1;
    end else if (running && overload_flag_reg) begin
      led_r_next = blink_reg;
      led_g_next = 1'b1;
    end else if (state_reg == VMS_SETTLE) begin
      led_r_next = 1'b0;
      led_g_next = blink_reg;
    end else if (running) begin
      led_r_next = 1'b0;
      led_g_next = 1'b1;
    end
  end

  assign LED_RED_OUT     = led_r_reg;
  assign LED_GREEN_OUT   = led_g_reg;
  assign OVERLOAD_OUT    = ovl_now_reg;
  assign UNDER_RANGE_OUT = under_reg;

  // ****************************************************
  // raw records
  // ****************************************************
  vms_rec_t rec_reg;
  logic     rec_vld_reg;

  // floats pass untouched: no weighting or integration on this path
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      rec_reg     <= '0;
      rec_vld_reg <= 1'b0;
    end else begin
      rec_vld_reg <= take & raw_en_reg;
      if (take && raw_en_reg) begin
        rec_reg <= '{z: SAMPLE_IN[2].raw, y: SAMPLE_IN[1].raw,
                     x: SAMPLE_IN[0].raw};
      end
    end
  end

  assign RAW_REC_OUT   = rec_reg;
  assign RAW_VALID_OUT = rec_vld_reg;

  // ****************************************************
  // annotations
  // ****************************************************
  logic [31:0] note_pre_reg;
  logic        note_pre_set_reg;
  logic [31:0] note_run_reg;
  logic [7:0]  note_cnt_reg;

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      note_pre_reg     <= 32'h0;
      note_pre_set_reg <= 1'b0;
      note_run_reg     <= 32'h0;
      note_cnt_reg     <= 8'h0;
    end else begin
      if (wr_npre && !running) begin
        note_pre_reg     <= wdata;
        note_pre_set_reg <= 1'b1;
      end
      if (wr_nrun) begin
        note_run_reg <= wdata;
        note_cnt_reg <= note_cnt_reg + 8'h1;
      end
    end
  end

  // ****************************************************
  // read selection
  // ****************************************************
  wire [31:0] status_word = {16'h0, note_cnt_reg, 1'b0, dirty_reg, note_pre_set_reg,
                             under_reg, overload_flag_reg, ovl_now_reg,
                             state_reg == VMS_SETTLE, running};
  wire [31:0] ch_word = (ch_fld == `VMS_CH_SUMSQ) ? pub_sumsq_reg[ch_idx] :
                        (ch_fld == `VMS_CH_MIN)   ? 32'(pub_min_reg[ch_idx]) :
                        (ch_fld == `VMS_CH_MAX)   ? 32'(pub_max_reg[ch_idx]) : 32'h0;

  assign rd_mux = (ADDRESS_IN == `VMS_CTRL_OFS)     ? {28'h0, raw_en_reg, 3'h0} :
                  (ADDRESS_IN == `VMS_STATUS_OFS)   ? status_word :
                  (ADDRESS_IN == `VMS_NOTE_PRE_OFS) ? note_pre_reg :
                  (ADDRESS_IN == `VMS_NOTE_RUN_OFS) ? note_run_reg :
                  (ADDRESS_IN == `VMS_SAMPLES_OFS)  ? pub_cnt_reg :
                  ch_hit                            ? ch_word : 32'h0;

  // ****************************************************
  // checks
  // ****************************************************
  clear_on_start_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    clr |=> (acc_sumsq_reg[0] == '0) && (pub_max_reg[3] == '0) && !overload_flag_reg
            || (running && $past(|OVER_IN)))
    else $error("overall results not cleared at run start");
  settle_entry_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    (state_reg == VMS_IDLE && sw_start && !stop_req && dirty_reg)
      |=> (state_reg == VMS_SETTLE) ##1 !LED_RED_OUT || ovl_now_reg)
    else $error("dirty start did not settle");
  button_start_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    btn_fire |-> !TEDS_BUSY_IN && $past(state_reg == VMS_IDLE) ##1 state_reg != VMS_IDLE)
    else $error("button start wrong");
  publish_tick_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    (tick && running && !clr) |=> pub_max_reg[1] == $past(acc_max_reg[1]))
    else $error("overall not published on tick");
  max_hold_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    (take && !clr && ch_mag[0] > acc_max_reg[0]) |=> acc_max_reg[0] == $past(ch_mag[0]))
    else $error("maximum hold missed");
  overload_now_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    (|OVER_IN) |=> OVERLOAD_OUT ##1 (LED_RED_OUT && LED_GREEN_OUT))
    else $error("overload not shown yellow");
  flag_keeps_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    (overload_flag_reg && !clr) |=> overload_flag_reg)
    else $error("overload flag dropped within run");
  blink_pair_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    (running && overload_flag_reg && !ovl_now_reg && !stop_req && !start_req)
      |=> LED_GREEN_OUT && (LED_RED_OUT == $past(blink_reg)))
    else $error("green yellow blink wrong");
  raw_layout_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    RAW_VALID_OUT |-> $past(raw_en_reg) && RAW_REC_OUT.x == $past(SAMPLE_IN[0].raw)
                      && RAW_REC_OUT.z == $past(SAMPLE_IN[2].raw))
    else $error("raw record wrong");
  note_run_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    (wr_nrun && running && !stop_req && !start_req) |=> running)
    else $error("annotation stopped run");

endmodule

//--- hw/vms_regs.svh
// register offsets, field positions, reset values and timing figures of the measure block
`ifndef VMS_REGS_SVH
`define VMS_REGS_SVH

// ****************************************************
// register byte offsets
// ****************************************************
`define VMS_CTRL_OFS      8'h00
`define VMS_STATUS_OFS    8'h04
`define VMS_NOTE_PRE_OFS  8'h08
`define VMS_NOTE_RUN_OFS  8'h0c
`define VMS_SAMPLES_OFS   8'h10
`define VMS_CH_BASE       4'h2
`define VMS_CH_LAST       4'h5
`define VMS_CH_SUMSQ      2'h0
`define VMS_CH_MIN        2'h1
`define VMS_CH_MAX        2'h2

// ****************************************************
// field positions and reset values
// ****************************************************
`define VMS_CTRL_START    0
`define VMS_CTRL_STOP     1
`define VMS_CTRL_CFGCHG   2
`define VMS_CTRL_RAW      3
`define VMS_RAW_EN_RST    1'b0
`define VMS_ST_RUN        0
`define VMS_ST_SETTLE     1
`define VMS_ST_OVL_NOW    2
`define VMS_ST_OVL_FLAG   3
`define VMS_ST_UNDER      4
`define VMS_ST_NOTE_PRE   5
`define VMS_ST_DIRTY      6

// ****************************************************
// timing: clock in hertz, times in their own units
// ****************************************************
`define VMS_CLK_HZ        64'h5f5e100
`define VMS_SETTLE_S      64'h1e
`define VMS_HOLD_MS       64'h3e8
`define VMS_BLINK_MS      64'h1f4
`define VMS_MS_PER_S      64'h3e8

`endif

//--- hw/vms_pkg.sv
// types shared by the vibration measure status block
package vms_pkg;

  typedef struct packed {
    logic [31:0] raw;
    logic [15:0] mag;
  } vms_axis_t;

  typedef struct packed {
    logic [31:0] z;
    logic [31:0] y;
    logic [31:0] x;
  } vms_rec_t;

  typedef enum logic [2:0] {
    VMS_IDLE   = 3'b001,
    VMS_SETTLE = 3'b010,
    VMS_RUN    = 3'b100
  } vms_state_t;

endpackage

//--- verification/vms_front_model.sv
// accelerometer front end model: per-axis samples, range levels, sensor id and change
`timescale 1ns/10ps
module vms_front_model
  import vms_pkg::*;
(
  input  wire logic       clk_in,
  output vms_axis_t [2:0] sample_out,
  output logic            valid_out,
  output logic [2:0]      over_out,
  output logic [2:0]      under_out,
  output logic            change_out,
  output logic            teds_busy_out
);
  initial begin
    sample_out = '0;
    valid_out = 1'b0;
    over_out = 3'h0;
    under_out = 3'h0;
    change_out = 1'b0;
    teds_busy_out = 1'b0;
  end
  // ****************************************************
  // one sample set, valid for a single cycle
  // ****************************************************
  task automatic send(input logic [31:0] rx, input logic [31:0] ry, input logic [31:0] rz,
                      input logic [15:0] mx);
    @(posedge clk_in);
    sample_out <= {rz, 16'h0, ry, 16'h0, rx, mx};
    valid_out <= 1'b1;
    @(posedge clk_in);
    // stale lines show the inverse so a late capture cannot pass by luck
    sample_out <= ~{rz, 16'h0, ry, 16'h0, rx, mx};
    valid_out <= 1'b0;
  endtask
  task automatic set_range(input logic [2:0] o, input logic [2:0] u);
    @(posedge clk_in);
    over_out <= o;
    under_out <= u;
  endtask
  task automatic set_teds(input logic b);
    @(posedge clk_in);
    teds_busy_out <= b;
  endtask
  task automatic pulse_change();
    @(posedge clk_in);
    change_out <= 1'b1;
    @(posedge clk_in);
    change_out <= 1'b0;
  endtask
endmodule

//--- verification/vibration_measure_status_tb.sv
// self-checking bench for the measure status block
`timescale 1ns/10ps
module vibration_measure_status_tb
  import vms_pkg::*;
;
  logic            clk;
  logic            rst_b;
  logic [7:0]      addr;
  logic            rd;
  logic            we;
  logic [31:0]     wdata;
  logic            button;
  logic [3:0]      be;
  logic [31:0]     q;
  vms_axis_t [2:0] smp;
  logic            svalid;
  logic [2:0]      over;
  logic [2:0]      under;
  logic            chg;
  logic            teds;
  logic [31:0]     rdata;
  logic            waitreq;
  logic            red;
  logic            green;
  logic            ovl;
  logic            undr;
  logic            rvalid;
  vms_rec_t        rec;
  int              err_count;
  int              comparisons;
  int              r;
  int              g;

  // short counts keep the run small
  vms_top #(.SETTLE_CYC(32'h32), .HOLD_CYC(32'h14), .TICK_CYC(32'h28), .BLINK_CYC(32'h4)) DUT (
    .CLK_IN(clk), .RST_B_IN(rst_b), .ADDRESS_IN(addr), .READ_IN(rd), .WRITE_IN(we),
    .WRITEDATA_IN(wdata), .BYTEENABLE_IN(be), .READDATA_OUT(rdata), .WAITREQUEST_OUT(waitreq),
    .SAMPLE_IN(smp), .SAMPLE_VALID_IN(svalid), .OVER_IN(over), .UNDER_IN(under),
    .SENSOR_CHANGE_IN(chg), .TEDS_BUSY_IN(teds), .BUTTON_IN(button), .LED_RED_OUT(red),
    .LED_GREEN_OUT(green), .OVERLOAD_OUT(ovl), .UNDER_RANGE_OUT(undr), .RAW_REC_OUT(rec),
    .RAW_VALID_OUT(rvalid));
  vms_front_model fe (.clk_in(clk), .sample_out(smp), .valid_out(svalid), .over_out(over),
    .under_out(under), .change_out(chg), .teds_busy_out(teds));

  initial clk = 1'b0;
  always #5 clk = ~clk;

  // ****************************************************
  // bus cycles and comparisons
  // ****************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wdata <= d;
    rd <= !w;
    we <= w;
    // request held until waitrequest is seen low at an edge
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    if (n >= 50) err_count++;
    q = rdata;
    rd <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  task automatic stc(input logic [31:0] m, input logic [31:0] exp);
    bus(1'b0, 8'h04, 32'h0);
    chk(q & m, exp);
  endtask
  task automatic leds(input int n);
    r = 0;
    g = 0;
    repeat (n) begin
      @(posedge clk);
      r += int'(red);
      g += int'(green);
    end
  endtask
  task automatic hold(input int n);
    @(posedge clk);
    button <= 1'b1;
    repeat (n) @(posedge clk);
    button <= 1'b0;
  endtask
  task automatic test_done();
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ****************************************************
  // scenarios
  // ****************************************************
  initial begin
    rst_b = 1'b0;
    addr = 8'h0;
    rd = 1'b0;
    we = 1'b0;
    wdata = 32'h0;
    button = 1'b0;
    be = 4'hf;
    err_count = 0;
    comparisons = 0;
    repeat (4) @(posedge clk);
    chk({29'h0, waitreq, red, green}, 32'h4);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    chk({30'h0, red, green}, 32'h2);
    rdc(8'h14, 32'h0);
    wr(8'h08, 32'habcd);
    wr(8'h14, 32'hffff_ffff);
    rdc(8'h08, 32'habcd);
    fe.set_teds(1'b1);
    hold(30);
    fe.set_teds(1'b0);
    stc(32'h3, 32'h0);
    hold(12);
    stc(32'h3, 32'h0);
    hold(25);
    repeat (70) @(posedge clk);
    stc(32'h1, 32'h1);
    wr(8'h00, 32'h2);
    wr(8'h00, 32'h1);
    stc(32'h3, 32'h1);
    fe.send(32'h1, 32'h2, 32'h3, 16'h5);
    @(posedge clk);
    chk({31'h0, rvalid}, 32'h0);
    wr(8'h00, 32'h9);
    rdc(8'h10, 32'h0);
    fe.send(32'h3f8c_cc12, 32'hbf80_0000, 32'h4120_0000, 16'h64);
    @(posedge clk);
    chk({31'h0, rvalid}, 32'h1);
    chk(rec[31:0], 32'h3f8c_cc12);
    chk(rec[63:32], 32'hbf80_0000);
    chk(rec[95:64], 32'h4120_0000);
    chk({24'h0, rec[7:0]}, 32'h12);
    fe.send(32'h0, 32'h0, 32'h0, 16'h32);
    fe.send(32'h0, 32'h0, 32'h0, 16'h12c);
    rdc(8'h28, 32'h0);
    repeat (40) @(posedge clk);
    rdc(8'h24, 32'h32);
    rdc(8'h28, 32'h12c);
    rdc(8'h20, 32'h1);
    rdc(8'h10, 32'h3);
    rdc(8'h54, 32'h32);
    rdc(8'h58, 32'h12c);
    stc(32'hff00, 32'h0);
    wr(8'h0c, 32'h1);
    wr(8'h0c, 32'h2);
    stc(32'hff01, 32'h0201);
    wr(8'h08, 32'h1234);
    rdc(8'h08, 32'habcd);
    fe.set_range(3'b010, 3'b000);
    repeat (3) @(posedge clk);
    chk({31'h0, ovl}, 32'h1);
    leds(4);
    chk(32'(r + g), 32'h8);
    fe.set_range(3'b000, 3'b000);
    repeat (3) @(posedge clk);
    leds(16);
    chk(32'(g), 32'h10);
    chk(32'(r > 0 && r < 16), 32'h1);
    fe.set_range(3'b001, 3'b000);
    repeat (3) @(posedge clk);
    leds(8);
    chk(32'(r + g), 32'h10);
    fe.set_range(3'b000, 3'b100);
    repeat (3) @(posedge clk);
    chk({31'h0, undr}, 32'h1);
    stc(32'h10, 32'h10);
    wr(8'h00, 32'h2);
    stc(32'h9, 32'h8);
    // upper bytes disabled: they must land as zero
    be <= 4'h3;
    wr(8'h08, 32'hffff_5678);
    be <= 4'hf;
    rdc(8'h08, 32'h5678);
    wr(8'h00, 32'h1);
    stc(32'h9, 32'h1);
    rdc(8'h28, 32'h0);
    wr(8'h00, 32'h2);
    wr(8'h00, 32'h4);
    stc(32'h40, 32'h40);
    wr(8'h00, 32'h2);
    fe.pulse_change();
    repeat (2) @(posedge clk);
    stc(32'h40, 32'h40);
    wr(8'h00, 32'h1);
    // led register still shows idle red for one edge after the start
    @(posedge clk);
    leds(16);
    chk(32'(r), 32'h0);
    chk(32'(g > 0 && g < 16), 32'h1);
    repeat (10) @(posedge clk);
    stc(32'h3, 32'h2);
    repeat (40) @(posedge clk);
    stc(32'h43, 32'h1);
    test_done();
  end

  // hang guard: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    test_done();
  end
endmodule
